// [logic/access_timer.v]
`timescale 1ns/1ps
// ==========================================================
// Counter that fires once when LIMIT cycles pass while running
module access_timer #(
  parameter WIDTH = 27,
  parameter [WIDTH-1:0] LIMIT = 27'd62_500_000
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Control
  input wire restart,
  input wire run,
  // Expiry pulse
  output reg expired
);
  reg [WIDTH-1:0] count;

  // Saturating count so expiry fires only once per run
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count <= {WIDTH{1'b0}};
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (restart || !run) begin
        count <= {WIDTH{1'b0}};
      end else if (count != LIMIT) begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        if (count == LIMIT - {{(WIDTH-1){1'b0}}, 1'b1}) begin
          expired <= 1'b1;
        end
      end
    end
  end
endmodule // access_timer

// [logic/line_sync.v]
`timescale 1ns/1ps
// ==========================================================
// Two-flop synchroniser with edge detect on the second stage
module line_sync (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Pin in
  input wire pin,
  // Synchronised level and edges
  output reg level,
  output wire rise,
  output wire fall
);
  reg meta;
  reg prev;

  // Idle bus rests high, so flops reset to one
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      meta <= 1'b1;
      level <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pin;
      level <= meta;
      prev <= level;
    end
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule // line_sync

// [logic/rtc_i2c_defines.vh]
`ifndef RTC_I2C_DEFINES_VH
`define RTC_I2C_DEFINES_VH

// ==========================================================
// Bus addressing, formats and idle read data
`define SLAVE_ADDR 7'h32
`define PTR_AFTER_STOP 4'hF
`define PTR_WRAP_TOP 4'hF
`define FMT_WRITE 4'h0
`define FMT_STREAM_READ 4'h4
`define IDLE_READ_DATA 8'hFF

// ==========================================================
// Timing, in the block clock
`define CLK_PERIOD_NS 8
// Access watchdog: release at 0.5 s after start (lower end of window)
`define WATCHDOG_MS 500
// Carry hold released within 61 us of stop
`define CARRY_APPLY_US 61

`endif

// [logic/rtc_i2c_slave.v]
`timescale 1ns/1ps
`include "rtc_i2c_defines.vh"

// Notes on behaviour
// - Idle bus rests with both lines high
// - Data fall with clock high starts
// - Data rise with clock high stops
// - Data changes only while clock low
// - Bytes of eight bits, any count
// - Receiver pulls data low for acknowledge
// - Acknowledge released at ninth clock fall
// - Master nack ends slave transmission
// - First byte: address MSB first, direction
// - Answer only to address 0110010
// - Repeated start re-sends address
// - Second write byte loads pointer, format
// - Write data stored, pointer increments
// - Pointer wraps from F to 0
// - Stop presets pointer to F
// - Format 4 streams read immediately
// - Direct read starts at current pointer
// - Outputs open drain, pull low only
// - Watchdog abandons access after 0.5 s
// - After watchdog: nack writes, FF reads
// - Time frozen during access, carry later
module rtc_i2c_slave #(
  parameter CLK_MHZ = 125,
  parameter WD_CYCLES = 62_500_000,
  parameter CARRY_CYCLES = 7625
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Serial clock pin (input only on this side)
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  // Serial data pin
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  // Register file port
  output reg [3:0] reg_addr,
  output reg [7:0] reg_wdata,
  output reg reg_write,
  input wire [7:0] reg_rdata,
  // Timekeeping hold
  output reg time_hold
);
  // Times as printed and the carry window's cycle count
  localparam WD_MS = `WATCHDOG_MS;
  localparam CARRY_US = `CARRY_APPLY_US;
  localparam CARRY_MAX = CARRY_US * CLK_MHZ;

  // Phase codes
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_PTR = 3'd2;
  localparam [2:0] ST_WDATA = 3'd3;
  localparam [2:0] ST_RDATA = 3'd4;
  localparam [2:0] ST_IGNORE = 3'd5;

  // ========================================================
  // Pin synchronisers
  wire scl;
  wire scl_rise;
  wire scl_fall;
  wire sda;
  wire sda_rise;
  wire sda_fall;

  line_sync u_scl (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin(scl_in),
    .level(scl),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  line_sync u_sda (
    .clk_sys(clk_sys),
    .reset(reset),
    .pin(sda_in),
    .level(sda),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  // Conditions only valid while clock is high
  wire start_cond = sda_fall & scl & ~scl_rise;
  wire stop_cond = sda_rise & scl & ~scl_rise;

  // ========================================================
  // State
  reg [2:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [3:0] pointer;
  reg [3:0] fmt;
  reg in_access;
  reg released;
  reg ack_phase;
  reg ack_drive;
  reg tx_drive;
  reg master_nack;
  reg [7:0] tx_byte;
  reg [12:0] carry_cnt;

  wire wd_expired;

  // Watchdog over a whole access, repeated starts included
  access_timer #(
    .WIDTH(27),
    .LIMIT(WD_CYCLES[26:0])
  ) u_wd (
    .clk_sys(clk_sys),
    .reset(reset),
    .restart(1'b0),
    .run(in_access),
    .expired(wd_expired)
  );

  // Read data source; FF once released
  wire [7:0] read_value = released ? `IDLE_READ_DATA : reg_rdata;

  // Open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe = ack_drive | tx_drive;
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;  // no clock hold, leaves bus control to master

  // ========================================================
  // Protocol engine
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      pointer <= `PTR_AFTER_STOP;
      fmt <= 4'h0;
      in_access <= 1'b0;
      released <= 1'b0;
      ack_phase <= 1'b0;
      ack_drive <= 1'b0;
      tx_drive <= 1'b0;
      master_nack <= 1'b0;
      tx_byte <= 8'h00;
      // Index mirrors the pointer from the first cycle
      reg_addr <= `PTR_AFTER_STOP;
      reg_wdata <= 8'h00;
      reg_write <= 1'b0;
    end else begin
      reg_write <= 1'b0;
      reg_addr <= pointer;
      if (stop_cond) begin
        // End of access from any phase
        state <= ST_IDLE;
        in_access <= 1'b0;
        released <= 1'b0;
        pointer <= `PTR_AFTER_STOP;
        ack_drive <= 1'b0;
        tx_drive <= 1'b0;
        ack_phase <= 1'b0;
      end else if (wd_expired) begin
        // Behave as stop; until a real stop, writes get nack and reads answer FF
        state <= ST_IGNORE;
        in_access <= 1'b0;
        released <= 1'b1;
        pointer <= `PTR_AFTER_STOP;
        ack_drive <= 1'b0;
        tx_drive <= 1'b0;
        ack_phase <= 1'b0;
      end else if (start_cond) begin
        // Fresh or repeated start: address comes next
        state <= ST_ADDR;
        in_access <= ~released;
        bit_cnt <= 4'h0;
        ack_phase <= 1'b0;
        ack_drive <= 1'b0;
        tx_drive <= 1'b0;
      end else if (scl_rise && state != ST_IDLE) begin
        // Sample on rising clock; data is stable while high
        if (ack_phase) begin
          master_nack <= sda;
        end else if (bit_cnt < 4'd8) begin
          shift <= {shift[6:0], sda};
          bit_cnt <= bit_cnt + 4'd1;
        end
      end else if (scl_fall && state != ST_IDLE) begin
        if (ack_phase) begin
          // Ninth clock falls: release or start sending
          ack_phase <= 1'b0;
          ack_drive <= 1'b0;
          bit_cnt <= 4'h0;
          if (state == ST_RDATA) begin
            if (master_nack) begin
              tx_drive <= 1'b0;
              state <= ST_IGNORE;
            end else begin
              tx_byte <= read_value;
              tx_drive <= ~read_value[7];
            end
          end
        end else if (bit_cnt == 4'd8) begin
          // Eighth clock falls: acknowledge slot
          ack_phase <= 1'b1;
          tx_drive <= 1'b0;
          case (state)
            ST_ADDR: begin
              if (shift[7:1] == `SLAVE_ADDR && !released) begin
                ack_drive <= 1'b1;
                if (shift[0]) begin
                  state <= ST_RDATA;
                end else begin
                  state <= ST_PTR;
                end
              end else if (shift[7:1] == `SLAVE_ADDR && shift[0]) begin
                // Released: reads still answer, with FF
                ack_drive <= 1'b1;
                state <= ST_RDATA;
              end else begin
                state <= ST_IGNORE;
              end
            end
            ST_PTR: begin
              pointer <= shift[7:4];
              fmt <= shift[3:0];
              ack_drive <= 1'b1;
              if (shift[3:0] == `FMT_STREAM_READ) begin
                state <= ST_RDATA;
              end else begin
                state <= ST_WDATA;
              end
            end
            ST_WDATA: begin
              reg_addr <= pointer;
              reg_wdata <= shift;
              reg_write <= 1'b1;
              pointer <= pointer + 4'd1;
              ack_drive <= 1'b1;
            end
            ST_RDATA: begin
              // Byte sent; master acks in this slot
              pointer <= pointer + 4'd1;
            end
            default: begin
              ack_drive <= 1'b0;
            end
          endcase
        end else if (state == ST_RDATA) begin
          // Shift out next bit, MSB first
          tx_byte <= {tx_byte[6:0], 1'b1};
          tx_drive <= ~tx_byte[6];
        end
      end else if (state == ST_RDATA && !ack_phase && bit_cnt == 4'd0
                   && !tx_drive && !scl) begin
        // First bit after address ack or stream entry
        tx_byte <= read_value;
        tx_drive <= ~read_value[7];
        bit_cnt <= 4'd0;
      end
    end
  end

  // ========================================================
  // Time hold and delayed carry window
  // The count may go stale during an access; the core applies carries
  // after hold drops; carry_cnt counts down after it but holds nothing off.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      time_hold <= 1'b0;
      carry_cnt <= 13'h0000;
    end else if (in_access) begin
      time_hold <= 1'b1;
      carry_cnt <= CARRY_CYCLES[12:0];
    end else if (carry_cnt != 13'h0000) begin
      // Carry applied well inside the window after stop
      time_hold <= 1'b0;
      carry_cnt <= carry_cnt - 13'h0001;
    end else begin
      time_hold <= 1'b0;
    end
  end
endmodule // rtc_i2c_slave

// [verif/i2c_master_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Bus master; clock rests high between frames
module i2c_master_model (
  // Bus clock and data pull-down
  output logic scl,
  output logic sda_low,
  // Wired data level
  input wire sda
);
  localparam int Q = 40;
  // Both lines released at rest
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Start or repeated start: data falls with clock high
  task automatic start();
    sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  // Stop: data rises with clock high
  task automatic stop();
    sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask
  // Nine clocks MSB first; a 1 leaves the line to the pull-up
  task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      sda_low = !tx[i];
      #Q scl = 1'b1;
      #Q rx[i] = sda;
      #Q scl = 1'b0;
      #Q;
    end
    sda_low = 1'b0;
  endtask
endmodule // i2c_master_model

// [verif/rtc_i2c_slave_properties.sv]
`timescale 1ns/1ps
// ==========================================================
// Bus-level properties of the serial slave, on its pins, register port and hold
module rtc_i2c_slave_properties #(
  parameter CLK_MHZ = 125,
  parameter WD_CYCLES = 62_500_000,
  parameter CARRY_CYCLES = 7625
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset,
  // Bus pins
  input wire scl_in,
  input wire scl_out,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  // Register file and hold
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire [7:0] reg_rdata,
  input wire time_hold
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Idle from stop to start; length of each hold
  // Idle only clears on a fresh start, so repeated starts are ignored
  logic idle;
  int held;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      idle <= 1'b1;
      held <= 0;
    end else begin
      held <= time_hold ? held + 1 : 0;
      if (scl_in && $rose(sda_in)) idle <= 1'b1;
      else if (scl_in && $fell(sda_in)) idle <= 1'b0;
    end
  end
  a_scl_never_driven: assert property (!scl_oe)
    else $error("clock line driven by slave");
  a_sda_pull_only: assert property (!sda_out)
    else $error("data line driven high");
  a_oe_moves_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  a_idle_released: assert property (idle |-> !sda_oe)
    else $error("data held low on idle bus");
  a_hold_at_start: assert property (
    idle && scl_in && $fell(sda_in) |-> ##[1:6] time_hold)
    else $error("start did not begin an access");
  a_hold_at_stop: assert property (
    scl_in && $rose(sda_in) |-> ##[1:6] !time_hold)
    else $error("stop did not end the access");
  a_ptr_at_stop: assert property (
    scl_in && $rose(sda_in) |-> ##[1:6] reg_addr == 4'hF)
    else $error("pointer not preset by stop");
  a_write_pulse: assert property (
    reg_write |-> time_hold && !scl_in ##1 !reg_write)
    else $error("bad register write pulse");
  a_watchdog_bound: assert property (held <= WD_CYCLES + 8)
    else $error("access held beyond watchdog");
endmodule // rtc_i2c_slave_properties

// [verif/rtc_i2c_slave_tb.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the serial slave
module rtc_i2c_slave_tb;
  // Short watchdog keeps the run brief
  localparam int WD = 2000;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic m_scl, m_low;
  wire scl_out, scl_oe, sda_out, sda_oe, reg_write, time_hold;
  wire [3:0] reg_addr;
  wire [7:0] reg_wdata;
  logic [7:0] regs [16];
  logic [8:0] rx;
  int n_errors = 0, n_checks = 0, cycles = 0;
  // Address probes: byte on the line and its ack bit
  logic [8:0] rows [5] = '{9'h0C8, 9'h0CA, 9'h0CD, 9'h1C9, 9'h065};
  logic [7:0] wbytes [5] = '{8'h64, 8'hE0, 8'hA1, 8'hB2, 8'hC3};
  // Wired-and lines with pull-ups
  wire scl_in = m_scl & !(scl_oe & !scl_out);
  wire sda_in = !m_low & !(sda_oe & !sda_out);
  wire [7:0] reg_rdata = regs[reg_addr];
  i2c_master_model m (.scl(m_scl), .sda_low(m_low), .sda(sda_in));
  rtc_i2c_slave #(.WD_CYCLES(WD)) DUT (
    .clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_rdata(reg_rdata), .time_hold(time_hold)
  );
  // Clock and register file
  initial forever #4 clk_sys = !clk_sys;
  initial for (int i = 0; i < 16; i++) regs[i] = 8'h00;
  always @(posedge clk_sys) if (reg_write) regs[reg_addr] <= reg_wdata;
  task automatic check(input string what, input logic [8:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Master writes a byte; the slave's ack is compared
  task automatic wr(input logic [7:0] b, input logic nack);
    m.byte_io({b, 1'b1}, rx);
    check("written byte", {b, nack}, rx);
  endtask
  // Master reads a byte, acking all but the last
  task automatic rd(input logic [7:0] exp, input logic last);
    m.byte_io({8'hFF, last}, rx);
    check("read byte", {exp, last}, rx);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Hang guard; the full run needs roughly 7400 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      $display("timeout after %0d cycles", cycles);
      end_of_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 reset = 1'b0;
    check("reset state", 9'h1E0, {reg_addr, sda_oe, time_hold, 3'b000});
    repeat (4) @(posedge clk_sys);
    foreach (rows[i]) begin
      m.start();
      m.byte_io({rows[i][8:1], 1'b1}, rx);
      check("address ack", rows[i], rx);
      // A selected read must be ended by nack so the stop can happen
      if (!rows[i][0] && rows[i][1]) m.byte_io(9'h1FF, rx);
      m.stop();
    end
    $display("test address probes done");
    m.start();
    foreach (wbytes[i]) wr(wbytes[i], 1'b0);
    m.stop();
    for (int i = 0; i < 3; i++) check("stored", {1'b0, wbytes[i + 2]}, {1'b0, regs[4'(14 + i)]});
    $display("test write with wrap done");
    m.start();
    wr(8'h64, 1'b0);
    wr(8'hE0, 1'b0);
    m.start();
    wr(8'h65, 1'b0);
    for (int i = 0; i < 3; i++) rd(wbytes[i + 2], i == 2);
    m.stop();
    $display("test repeated start read done");
    m.start();
    wr(8'h64, 1'b0);
    wr(8'hF4, 1'b0);
    rd(8'hB2, 1'b0);
    rd(8'hC3, 1'b1);
    m.stop();
    $display("test stream read done");
    m.start();
    wr(8'h65, 1'b0);
    rd(8'hB2, 1'b1);
    m.stop();
    $display("test direct read done");
    m.start();
    wr(8'h64, 1'b0);
    repeat (WD + 100) @(posedge clk_sys);
    check("after watchdog", 9'h1E0, {reg_addr, 1'b0, time_hold, 3'b000});
    wr(8'hE0, 1'b1);
    m.start();
    wr(8'h65, 1'b0);
    rd(8'hFF, 1'b1);
    m.stop();
    $display("test watchdog release done");
    end_of_test();
  end
endmodule // rtc_i2c_slave_tb

bind rtc_i2c_slave rtc_i2c_slave_properties #(
  .CLK_MHZ(CLK_MHZ), .WD_CYCLES(WD_CYCLES), .CARRY_CYCLES(CARRY_CYCLES)
) u_props (
  .clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .scl_out(scl_out),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_rdata(reg_rdata), .time_hold(time_hold)
);
